// ### core/xbus_pin_gpio_config.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
// Functional notes
// - Bit 0 one makes input, zero output.
// - Bit 1 one inverts pin versus data.
// - Bit 7 one open drain, zero push-pull.
// - Bit 2 hands first eight pins to bus.
// - Power-on loads bus pins with 0x04.
// - Power-on loads plain pins with 0x80.
// - Out-of-range base ignores reads and writes.
module xbus_pin_gpio_config #(
  parameter int NUM_PINS = xgp_pkg::NUM_PINS,
  parameter int NUM_BUS_PINS = xgp_pkg::NUM_BUS_PINS
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register port.
  input wire logic [xgp_pkg::AXI_ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [xgp_pkg::AXI_DATA_W-1:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [xgp_pkg::AXI_ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [xgp_pkg::AXI_DATA_W-1:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // High while the programmed base address is in the permitted range.
  input wire logic base_in_range,
  // GPIO data path: level to drive, and sampled level after polarity.
  input wire logic [NUM_PINS-1:0] gpio_out,
  output logic [NUM_PINS-1:0] gpio_in,
  // External bus logic: drive level, drive enable, sampled level.
  input wire logic [NUM_BUS_PINS-1:0] xbus_drive,
  input wire logic [NUM_BUS_PINS-1:0] xbus_drive_en,
  output logic [NUM_BUS_PINS-1:0] xbus_sample,
  // Pads, split into input, output and output enable.
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe
);

  // =====================================================================
  // Configuration storage
  // =====================================================================

  // One byte per pin, packed so a whole-bank comparison is one operand.
  logic [NUM_PINS-1:0][7:0] cfg_reg;
  // Decoded controls handed to each pin cell.
  xgp_pkg::pin_ctl_t [NUM_PINS-1:0] pin_ctl;
  // Write request raised by the bus port for exactly one cycle.
  xgp_pkg::cfg_wr_t wr_req;
  // Byte offered to the read side for the address on the read channel.
  logic [7:0] rd_byte;
  // Word index and slot of the address on the read channel.
  logic [9:0] ar_word;
  logic [3:0] ar_slot;
  // Bus signals widened to the full pin count; plain pins get zero.
  logic [NUM_PINS-1:0] bus_drive_w;
  logic [NUM_PINS-1:0] bus_drive_en_w;
  logic [NUM_PINS-1:0] bus_sample_w;
  // Level the GPIO path asks for after polarity, for checking only.
  logic [NUM_PINS-1:0] gpio_level;

  assign bus_drive_w = {{(NUM_PINS-NUM_BUS_PINS){1'b0}}, xbus_drive};
  assign bus_drive_en_w = {{(NUM_PINS-NUM_BUS_PINS){1'b0}},
                           xbus_drive_en};
  assign xbus_sample = bus_sample_w[NUM_BUS_PINS-1:0];
  assign ar_word = s_araddr[xgp_pkg::AXI_ADDR_W-1:2];
  assign ar_slot = xgp_pkg::cfg_slot(ar_word);

  // =====================================================================
  // Register port
  // =====================================================================

  // Read data lookup; an out-of-range base or a miss returns zero, so
  // no state of the pins leaks out when access is not permitted.
  always_comb begin
    rd_byte = 8'h00;
    if (base_in_range && xgp_pkg::cfg_hit(ar_word)) begin
      rd_byte = cfg_reg[ar_slot];
    end
  end

  // The bus slave owns all channel handshakes and response timing.
  axil_cfg_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .base_in_range(base_in_range),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .rd_byte(rd_byte),
    .wr_req(wr_req)
  );

  // =====================================================================
  // Per-pin registers and pad logic
  // =====================================================================

  // The checks below all sample on the rising clock outside reset.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    // Bus-capable pins keep the select bit; the others hold it at zero.
    localparam bit HAS_ALT = (i < NUM_BUS_PINS);
    localparam logic [7:0] MASK = HAS_ALT ? xgp_pkg::BUS_PIN_CFG_MASK :
                                  xgp_pkg::PLAIN_PIN_CFG_MASK;
    localparam logic [7:0] RESET = HAS_ALT ? xgp_pkg::BUS_PIN_CFG_RESET :
                                   xgp_pkg::PLAIN_PIN_CFG_RESET;

    // Storage; reserved bits are dropped on write so they read as zero
    // and can never steer the pin.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_reg[i] <= RESET;
      end else if (wr_req.en && (wr_req.slot == 4'(i))) begin
        cfg_reg[i] <= wr_req.data & MASK;
      end
    end

    // Field decode.
    assign pin_ctl[i].is_input = cfg_reg[i][xgp_pkg::DIR_BIT];
    assign pin_ctl[i].invert = cfg_reg[i][xgp_pkg::POL_BIT];
    assign pin_ctl[i].alt_sel = cfg_reg[i][xgp_pkg::ALT_BIT];
    assign pin_ctl[i].drive_od = cfg_reg[i][xgp_pkg::DRV_BIT];
    assign gpio_level[i] = gpio_out[i] ^ pin_ctl[i].invert;

    // Pad cell; on a bus-owned pin the GPIO level is not consulted.
    pin_cell #(
      .HAS_ALT(HAS_ALT)
    ) u_cell (
      .aclk(aclk),
      .aresetn(aresetn),
      .ctl(pin_ctl[i]),
      .gpio_out(gpio_out[i]),
      .bus_out(bus_drive_w[i]),
      .bus_oe(bus_drive_en_w[i]),
      .pin_in(pin_in[i]),
      .pin_out(pin_out[i]),
      .pin_oe(pin_oe[i]),
      .gpio_in(gpio_in[i]),
      .bus_in(bus_sample_w[i])
    );

    // A GPIO pin set as input never drives the pad.
    property p_dir_input;
      (!(HAS_ALT && pin_ctl[i].alt_sel) && pin_ctl[i].is_input)
        |=> !pin_oe[i];
    endproperty
    a_dir_input: assert property (p_dir_input)
      else $error("input pin is driving the pad");

    // Push-pull GPIO output shows the data bit after polarity.
    property p_pol_out;
      (!(HAS_ALT && pin_ctl[i].alt_sel) && !pin_ctl[i].is_input &&
       !pin_ctl[i].drive_od)
        |=> pin_oe[i] && (pin_out[i] == $past(gpio_level[i]));
    endproperty
    a_pol_out: assert property (p_pol_out)
      else $error("output level ignores polarity");

    // The sampled level returns through the same polarity.
    property p_pol_in;
      1'b1 |=> gpio_in[i] == ($past(pin_in[i]) ^ $past(pin_ctl[i].invert));
    endproperty
    a_pol_in: assert property (p_pol_in)
      else $error("input level ignores polarity");

    // Open drain pulls low for a zero and floats for a one.
    property p_open_drain;
      (!(HAS_ALT && pin_ctl[i].alt_sel) && !pin_ctl[i].is_input &&
       pin_ctl[i].drive_od)
        |=> !pin_out[i] && (pin_oe[i] == !$past(gpio_level[i]));
    endproperty
    a_open_drain: assert property (p_open_drain)
      else $error("open drain output drives high");

    // Stored reserved bits stay zero whatever was written.
    property p_reserved;
      (wr_req.en && (wr_req.slot == 4'(i)))
        |=> cfg_reg[i] == ($past(wr_req.data) & MASK);
    endproperty
    a_reserved: assert property (p_reserved)
      else $error("reserved bits were stored");

    if (HAS_ALT) begin : g_bus_checks
      // A bus-owned push-pull pin follows the bus logic exactly.
      property p_bus_route;
        (pin_ctl[i].alt_sel && !pin_ctl[i].drive_od)
          |=> (pin_out[i] == $past(bus_drive_w[i])) &&
              (pin_oe[i] == $past(bus_drive_en_w[i]));
      endproperty
      a_bus_route: assert property (p_bus_route)
        else $error("bus pin not driven by bus logic");

      // Toggling the GPIO data leaves a bus-owned pin untouched. The
      // cycle after reset is left out, since the pads were forced idle.
      property p_bus_owns;
        ($past(aresetn) && pin_ctl[i].alt_sel && $stable(bus_drive_w[i]) &&
         $stable(bus_drive_en_w[i]) && $stable(cfg_reg[i]))
          |=> $stable(pin_out[i]) && $stable(pin_oe[i]) &&
              (bus_sample_w[i] == $past(pin_in[i]));
      endproperty
      a_bus_owns: assert property (p_bus_owns)
        else $error("GPIO data disturbed a bus pin");

      // Leaving reset the bus pin holds its bus default.
      property p_bus_reset;
        $rose(aresetn) |-> cfg_reg[i] == xgp_pkg::BUS_PIN_CFG_RESET;
      endproperty
      a_bus_reset: assert property (p_bus_reset)
        else $error("bus pin reset value wrong");
    end else begin : g_plain_checks
      // Leaving reset the plain pin holds its open-drain default.
      property p_plain_reset;
        $rose(aresetn) |-> cfg_reg[i] == xgp_pkg::PLAIN_PIN_CFG_RESET;
      endproperty
      a_plain_reset: assert property (p_plain_reset)
        else $error("plain pin reset value wrong");
    end
  end

  // =====================================================================
  // Access gating checks
  // =====================================================================

  // Address and data taken on one edge.
  sequence s_both_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence

  // Such a write whose request is formed while the base is out of range.
  sequence s_write_out_of_range;
    s_both_taken ##1 !base_in_range;
  endsequence

  // A write under an out-of-range base is answered but changes nothing.
  property p_ignore_write;
    s_write_out_of_range |=> s_bvalid ##1 $stable(cfg_reg);
  endproperty
  a_ignore_write: assert property (p_ignore_write)
    else $error("write landed while base out of range");

  // A read under an out-of-range base returns zero on the next cycle.
  property p_ignore_read;
    (s_arvalid && s_arready && !base_in_range)
      |=> s_rvalid && (s_rdata == '0);
  endproperty
  a_ignore_read: assert property (p_ignore_read)
    else $error("read returned data while base out of range");

endmodule : xbus_pin_gpio_config

// ### core/xgp_pkg.sv
// =====================================================================
// Shared constants, carriers and helpers for the pin configuration block.
// =====================================================================
package xgp_pkg;

  // Ten configurable pins; the first eight can carry the external bus.
  localparam int NUM_PINS = 10;
  localparam int NUM_BUS_PINS = 8;

  // AXI4-Lite geometry seen by the register port.
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;

  // =====================================================================
  // Register indices; the byte address of each is four times its index.
  // =====================================================================
  localparam logic [9:0] WRITE_STROBE_PIN_CFG_IDX = 10'h0e0;
  localparam logic [9:0] READ_STROBE_PIN_CFG_IDX = 10'h0e1;
  localparam logic [9:0] ADDR_BIT0_PIN_CFG_IDX = 10'h0e2;
  localparam logic [9:0] ADDR_BIT1_PIN_CFG_IDX = 10'h0e3;
  localparam logic [9:0] ADDR_BIT2_PIN_CFG_IDX = 10'h0e4;
  localparam logic [9:0] ADDR_BIT3_PIN_CFG_IDX = 10'h0e5;
  localparam logic [9:0] SELECT0_PIN_CFG_IDX = 10'h0e6;
  localparam logic [9:0] SELECT1_PIN_CFG_IDX = 10'h0e7;
  localparam logic [9:0] PLAIN_PIN_A_CFG_IDX = 10'h0e8;
  localparam logic [9:0] PLAIN_PIN_B_CFG_IDX = 10'h0e9;

  // =====================================================================
  // Field positions, implemented-bit masks and reset values.
  // =====================================================================
  localparam int DIR_BIT = 0;
  localparam int POL_BIT = 1;
  localparam int ALT_BIT = 2;
  localparam int DRV_BIT = 7;
  localparam logic [7:0] BUS_PIN_CFG_MASK = 8'h87;
  localparam logic [7:0] PLAIN_PIN_CFG_MASK = 8'h83;
  localparam logic [7:0] BUS_PIN_CFG_RESET = 8'h04;
  localparam logic [7:0] PLAIN_PIN_CFG_RESET = 8'h80;

  // AXI response codes used by the port.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded control of one pin.
  typedef struct packed {
    logic drive_od;
    logic alt_sel;
    logic invert;
    logic is_input;
  } pin_ctl_t;

  // One-cycle register write request from the bus port.
  typedef struct packed {
    logic en;
    logic [3:0] slot;
    logic [7:0] data;
  } cfg_wr_t;

  // True when a word index lands on one of the ten registers.
  function automatic logic cfg_hit(input logic [9:0] word);
    return (word >= WRITE_STROBE_PIN_CFG_IDX) &&
           (word <= PLAIN_PIN_B_CFG_IDX);
  endfunction : cfg_hit

  // Register slot, zero for the first pin, for a word index that hits.
  function automatic logic [3:0] cfg_slot(input logic [9:0] word);
    logic [9:0] diff;
    diff = word - WRITE_STROBE_PIN_CFG_IDX;
    return diff[3:0];
  endfunction : cfg_slot

endpackage : xgp_pkg

// ### core/pin_cell.sv
`timescale 1ns/1ns
// =====================================================================
// One pin: chooses bus or GPIO source, applies polarity and driver type.
// =====================================================================
module pin_cell #(
  parameter bit HAS_ALT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input xgp_pkg::pin_ctl_t ctl,
  input wire logic gpio_out,
  input wire logic bus_out,
  input wire logic bus_oe,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic gpio_in,
  output logic bus_in
);

  logic use_bus; // Pin handed to the bus logic.
  logic drive_en; // Source wants the pin driven.
  logic level; // Logic level the source wants on the pin.

  // Source selection; the select bit only exists on bus-capable pins.
  always_comb begin
    use_bus = HAS_ALT && ctl.alt_sel;
    if (use_bus) begin
      drive_en = bus_oe;
      level = bus_out;
    end else begin
      drive_en = !ctl.is_input;
      level = gpio_out ^ ctl.invert;
    end
  end

  // Pad drive; open drain only ever pulls low and floats for a one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (ctl.drive_od) begin
      pin_out <= 1'b0;
      pin_oe <= drive_en && !level;
    end else begin
      pin_out <= level;
      pin_oe <= drive_en;
    end
  end

  // Sampled pad level back to the GPIO data path and the bus logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_in <= 1'b0;
      bus_in <= 1'b0;
    end else begin
      gpio_in <= pin_in ^ ctl.invert;
      bus_in <= use_bus && pin_in;
    end
  end

endmodule : pin_cell

// ### core/axil_cfg_port.sv
`timescale 1ns/1ns
// =====================================================================
// AXI4-Lite slave that turns bus traffic into register requests.
// =====================================================================
module axil_cfg_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic base_in_range,
  input wire logic [xgp_pkg::AXI_ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [xgp_pkg::AXI_DATA_W-1:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [xgp_pkg::AXI_ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [xgp_pkg::AXI_DATA_W-1:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic [7:0] rd_byte,
  output xgp_pkg::cfg_wr_t wr_req
);

  typedef enum logic {W_COLLECT, W_RESP} wr_state_t;

  wr_state_t wr_state_reg; // Write channel phase.
  logic [9:0] aw_word_reg; // Captured write word index.
  logic [7:0] w_byte_reg; // Captured low data byte.
  logic w_lane_reg; // Captured strobe of the low byte lane.
  logic aw_hit; // Captured address lands on a register.

  assign aw_hit = xgp_pkg::cfg_hit(aw_word_reg);

  // Write path: address and data are caught in either order, then the
  // request and the response leave together one edge later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= W_COLLECT;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= xgp_pkg::RESP_OKAY;
      aw_word_reg <= '0;
      w_byte_reg <= '0;
      w_lane_reg <= 1'b0;
      wr_req <= '0;
    end else begin
      wr_req.en <= 1'b0;
      case (wr_state_reg)
        W_COLLECT: begin
          if (s_awvalid && s_awready) begin
            aw_word_reg <= s_awaddr[xgp_pkg::AXI_ADDR_W-1:2];
            s_awready <= 1'b0;
          end
          if (s_wvalid && s_wready) begin
            w_byte_reg <= s_wdata[7:0];
            w_lane_reg <= s_wstrb[0];
            s_wready <= 1'b0;
          end
          if (!s_awready && !s_wready) begin
            // An out-of-range base silently drops the write.
            wr_req.en <= base_in_range && aw_hit && w_lane_reg;
            wr_req.slot <= xgp_pkg::cfg_slot(aw_word_reg);
            wr_req.data <= w_byte_reg;
            s_bresp <= aw_hit ? xgp_pkg::RESP_OKAY : xgp_pkg::RESP_SLVERR;
            s_bvalid <= 1'b1;
            wr_state_reg <= W_RESP;
          end
        end
        W_RESP: begin
          if (s_bready) begin
            s_bvalid <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            wr_state_reg <= W_COLLECT;
          end
        end
        default: wr_state_reg <= W_COLLECT;
      endcase
    end
  end

  // Read path: data is captured on the address handshake itself.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= xgp_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= {{(xgp_pkg::AXI_DATA_W-8){1'b0}}, rd_byte};
      s_rresp <= xgp_pkg::cfg_hit(s_araddr[xgp_pkg::AXI_ADDR_W-1:2]) ?
                 xgp_pkg::RESP_OKAY : xgp_pkg::RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

endmodule : axil_cfg_port

// ### bench/tb_top.sv
`timescale 1ns/1ns
// =====================================================================
// Self-checking bench for the pin configuration block.
// =====================================================================
module tb_top;
  // Expected results travel from the drivers to the monitor in order.
  typedef struct {
    int kind;
    logic [39:0] val;
  } note_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_awaddr = 12'h000;
  logic s_awvalid = 1'b0;
  logic s_awready;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hf;
  logic s_wvalid = 1'b0;
  logic s_wready;
  logic [1:0] s_bresp;
  logic s_bvalid;
  logic s_bready = 1'b0;
  logic [11:0] s_araddr = 12'h000;
  logic s_arvalid = 1'b0;
  logic s_arready;
  logic [31:0] s_rdata;
  logic [1:0] s_rresp;
  logic s_rvalid;
  logic s_rready = 1'b0;
  logic base_in_range = 1'b1;
  logic [9:0] gpio_out = 10'h0;
  logic [9:0] gpio_in;
  logic [7:0] xbus_drive = 8'h0;
  logic [7:0] xbus_drive_en = 8'h0;
  logic [7:0] xbus_sample;
  logic [9:0] pin_in = 10'h0;
  logic [9:0] pin_out;
  logic [9:0] pin_oe;
  // High for one cycle when the monitor should sample the pins.
  logic pin_probe = 1'b0;
  logic [7:0] cfg_m [10];
  note_t note_q [$];
  string nm [3] = '{"bresp", "read", "pins"};
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;

  // 100 ns period for the 10 MHz clock.
  always #50 aclk = ~aclk;

  xbus_pin_gpio_config dut (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .base_in_range, .gpio_out, .gpio_in, .xbus_drive,
    .xbus_drive_en, .xbus_sample, .pin_in, .pin_out, .pin_oe
  );

  // =====================================================================
  // Closing report, reached from the main flow or the hang guard.
  // =====================================================================
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // A hang costs a mismatch; the whole plan needs under 3000 cycles.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_fail++;
      test_done();
    end
  end

  // =====================================================================
  // Monitor: pops the oldest note whenever a result shows up.
  // =====================================================================
  task automatic take(input int k, input logic [39:0] got);
    note_t n;
    total_checks++;
    if (note_q.size() == 0) begin
      n_fail++;
      $display("CHECK FAILED %s expected none seen %h", nm[k], got);
    end else begin
      n = note_q.pop_front();
      if (n.kind != k || n.val !== got) begin
        n_fail++;
        $display("CHECK FAILED %s expected %h seen %h", nm[k], n.val, got);
      end
    end
  endtask : take

  // Pin outputs are masked by enable, since an undriven level is free.
  always @(posedge aclk) begin
    if (s_bvalid && s_bready) begin
      take(0, {38'h0, s_bresp});
    end
    if (s_rvalid && s_rready) begin
      take(1, {6'h0, s_rresp, s_rdata});
    end
    if (pin_probe) begin
      take(2, {2'h0, pin_out & pin_oe, pin_oe, gpio_in, xbus_sample});
    end
  end

  // =====================================================================
  // Reference model of the pins and register helpers.
  // =====================================================================
  function automatic logic [39:0] model(input logic [9:0] g,
      input logic [7:0] xd, input logic [7:0] xe, input logic [9:0] pi);
    logic [9:0] po, oe, gi;
    logic [7:0] xs;
    logic alt, lvl;
    for (int i = 0; i < 10; i++) begin
      alt = (i < 8) && cfg_m[i][2];
      lvl = alt ? xd[i % 8] : g[i] ^ cfg_m[i][1];
      // Open drain only ever pulls low, so a high level releases it.
      oe[i] = (alt ? xe[i % 8] : !cfg_m[i][0]) && !(cfg_m[i][7] && lvl);
      po[i] = oe[i] && !cfg_m[i][7] && lvl;
      gi[i] = pi[i] ^ cfg_m[i][1];
      if (i < 8) begin
        xs[i] = alt ? pi[i] : 1'b0;
      end
    end
    return {2'h0, po, oe, gi, xs};
  endfunction : model

  function automatic logic [11:0] addr(input int i);
    return {xgp_pkg::WRITE_STROBE_PIN_CFG_IDX + 10'(i), 2'b00};
  endfunction : addr

  task automatic reset_model();
    for (int i = 0; i < 10; i++) begin
      cfg_m[i] = (i < 8) ? 8'h04 : 8'h80;
    end
  endtask : reset_model

  // =====================================================================
  // Bus master tasks; each holds its request until it is taken.
  // =====================================================================
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    note_q.push_back('{0, {38'h0, r}});
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_awready) begin
        aw_ok = 1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready) begin
        w_ok = 1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_bvalid);
    s_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r);
    note_q.push_back('{1, {6'h0, r, d}});
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    while (!s_rvalid) @(posedge aclk);
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  // Pins answer one cycle late; the probe lands two edges later.
  task automatic pins(input logic [9:0] g, input logic [7:0] xd,
      input logic [7:0] xe, input logic [9:0] pi);
    gpio_out <= g;
    xbus_drive <= xd;
    xbus_drive_en <= xe;
    pin_in <= pi;
    repeat (2) @(posedge aclk);
    note_q.push_back('{2, model(g, xd, xe, pi)});
    pin_probe <= 1'b1;
    @(posedge aclk);
    pin_probe <= 1'b0;
  endtask : pins

  task automatic check_defaults();
    reset_model();
    for (int i = 0; i < 10; i++) begin
      axi_rd(addr(i), {24'h0, cfg_m[i]}, 2'h0);
    end
    pins(10'h2aa, 8'h3c, 8'hf0, 10'h155);
  endtask : check_defaults

  // =====================================================================
  // Main sequence.
  // =====================================================================
  initial begin
    int j;
    logic [31:0] v;
    v = $urandom(32'h1e54);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_defaults();
    // Random settings cover every field, reserved bits included.
    for (int k = 0; k < 120; k++) begin
      j = $urandom_range(9);
      v = $urandom;
      axi_wr(addr(j), v, 2'h0);
      cfg_m[j] = v[7:0] & ((j < 8) ? xgp_pkg::BUS_PIN_CFG_MASK :
                           xgp_pkg::PLAIN_PIN_CFG_MASK);
      axi_rd(addr(j), {24'h0, cfg_m[j]}, 2'h0);
      pins(10'($urandom), 8'($urandom), 8'($urandom), 10'($urandom));
    end
    // Just outside the mapped words on both sides.
    axi_wr(12'h37c, 32'hff, 2'h2);
    axi_rd(12'h37c, 32'h0, 2'h2);
    axi_wr(12'h3a8, 32'hff, 2'h2);
    axi_rd(12'h3a8, 32'h0, 2'h2);
    // Base outside its range: accesses are dropped without error.
    base_in_range <= 1'b0;
    axi_wr(addr(9), {24'h0, ~cfg_m[9]}, 2'h0);
    axi_rd(addr(9), 32'h0, 2'h0);
    base_in_range <= 1'b1;
    axi_rd(addr(9), {24'h0, cfg_m[9]}, 2'h0);
    pins(10'h0f0, 8'h0f, 8'hff, 10'h30f);
    // Second reset in mid-run restores every default.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_defaults();
    repeat (4) @(posedge aclk);
    if (note_q.size() != 0) begin
      n_fail++;
      $display("CHECK FAILED queue expected 0 seen %0d", note_q.size());
    end
    test_done();
  end
endmodule : tb_top
